// File: include/bus_wake_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the bus and wake status bank
// Assumes: Included by its bare name wherever a figure is needed
// Notes: Definitions only
`ifndef BUS_WAKE_CONSTS_SVH
`define BUS_WAKE_CONSTS_SVH
// Register addresses, seven-bit command field
`define BWS_ADDR_BUS 7'h43
`define BWS_ADDR_WAKE 7'h44
// Command byte: top bit asks for a clear
`define BWS_CMD_CLEAR_BIT 7
// Bus fault status fields
`define BWS_LIN_FAIL_HI 6
`define BWS_LIN_FAIL_LO 5
`define BWS_CAN_TIMEOUT_FLAG_BIT 4
`define BWS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT 3
`define BWS_CAN_FAIL_HI 2
`define BWS_CAN_FAIL_LO 1
`define BWS_CAN_UV_BIT 0
`define BWS_CAN_TIMEOUT_IRQ_MASK 16'h0010
// Wake source status fields
`define BWS_LIN_WAKE_BIT 10
`define BWS_CAN_WAKE_BIT 9
`define BWS_TIMER2_WAKE_BIT 8
`define BWS_TIMER1_WAKE_BIT 7
`define BWS_INPUT_WAKE_LO 0
`define BWS_INPUT_WAKE_HI 3
// Power-on values and bits that survive a restart
`define BWS_BUS_RESET 16'h0000
`define BWS_WAKE_RESET 16'h0000
`define BWS_BUS_RESTART_KEEP 16'h007F
`define BWS_WAKE_RESTART_KEEP 16'h0782
// Implemented bits; all others read zero
`define BWS_BUS_IMPL 16'h007F
`define BWS_WAKE_IMPL 16'h078F
// Selective wake error counter limit
`define BWS_SWK_ERR_LIMIT 6'h20
// Interrupt pulse width
`define BWS_CLK_PERIOD_NS 10
`define BWS_INT_PULSE_NS 1000
`define BWS_INT_PULSE_CYC (`BWS_INT_PULSE_NS / `BWS_CLK_PERIOD_NS)
// Link frame: command byte then one status word
`define BWS_CMD_BITS 5'h08
`define BWS_CNT_MAX 5'h1F
`endif

// File: include/bus_wake_pkg.sv
// Purpose: Types and shared decode for the bus and wake status bank
// Assumes: Nothing beyond the consts header
// Notes: Mode encodings are local choices
package bus_wake_pkg;
  // Device operating mode seen by this bank
  typedef enum logic [2:0] {
    DEV_INIT = 3'b000,
    DEV_NORMAL = 3'b001,
    DEV_STOP = 3'b010,
    DEV_SLEEP = 3'b011,
    DEV_RESTART = 3'b100,
    DEV_FAIL_SAFE = 3'b101
  } dev_mode_e;
  // CAN transceiver mode
  typedef enum logic [1:0] {
    CAN_OFF = 2'b00,
    CAN_NORMAL = 2'b01,
    CAN_RX_ONLY = 2'b10,
    CAN_WAKE = 2'b11
  } can_mode_e;
  // Transceiver fault code, shared by LIN and CAN fields
  typedef enum logic [1:0] {
    FLT_NONE = 2'b00,
    FLT_TSD = 2'b01,
    FLT_TXD_DOM = 2'b10,
    FLT_BUS_DOM = 2'b11
  } fault_code_e;
  // Address match of a command byte
  function automatic logic addr_hit(input logic [7:0] cmd, input logic [6:0] addr);
    return cmd[6:0] == addr;
  endfunction : addr_hit
endpackage : bus_wake_pkg

// File: hdl/level_sync2.sv
// Purpose: Two-flop level synchroniser into the core clock
// Assumes: Inputs are quasi-static levels
// Notes: First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module level_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r; // First stage, read by second stage only
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] hold_r; // Second stage, safe to use
  logic [WIDTH-1:0] hold_nxt;

  // Shift both stages while enabled
  always_comb begin
    meta_nxt = ce ? async_in : meta_r;
    hold_nxt = ce ? meta_r : hold_r;
  end

  // Register stages; reset state is idle-high for chip select
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= {WIDTH{1'b1}};
      hold_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign sync_out = hold_r;
endmodule : level_sync2
`default_nettype wire

// File: hdl/spi_status_link.sv
// Purpose: Serial link end on the link clock: command byte in, status word out
// Assumes: Mode 0, MSB first, chip select low frames a command byte then 16 data bits
// Notes: Chip select high resets all link state, so no edge outside a frame is needed
`timescale 1ns/10ps
`default_nettype none
`include "bus_wake_consts.svh"
module spi_status_link (
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [15:0] snap_bus,
  input wire logic [15:0] snap_wake,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic [7:0] cmd_r,
  output logic cmd_valid_r
);
  import bus_wake_pkg::*;
  logic [4:0] bit_cnt_r; // Rising edges seen in this frame
  logic [4:0] bit_cnt_nxt;
  logic [7:0] cmd_nxt;
  logic cmd_valid_nxt;
  logic [15:0] out_sr_r; // Outgoing word, MSB on the pin
  logic [15:0] out_sr_nxt;
  logic oe_r;
  logic oe_nxt;

  // Sample side: shift in the command byte, then hold it for the core
  always_comb begin
    bit_cnt_nxt = (bit_cnt_r == `BWS_CNT_MAX) ? bit_cnt_r : bit_cnt_r + 5'h01;
    cmd_nxt = (bit_cnt_r < `BWS_CMD_BITS) ? {cmd_r[6:0], spi_mosi} : cmd_r;
    cmd_valid_nxt = cmd_valid_r | (bit_cnt_r == `BWS_CMD_BITS - 5'h01);
  end

  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_r <= 5'h00;
      cmd_r <= 8'h00;
      cmd_valid_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      cmd_r <= cmd_nxt;
      cmd_valid_r <= cmd_valid_nxt;
    end
  end

  // Launch side: load the addressed word once the byte is in, then shift
  always_comb begin
    oe_nxt = 1'b1;
    out_sr_nxt = {out_sr_r[14:0], 1'b0};
    if (bit_cnt_r == `BWS_CMD_BITS) begin
      // Unmapped address answers all zeros
      if (addr_hit(cmd_r, `BWS_ADDR_BUS))
        out_sr_nxt = snap_bus;
      else if (addr_hit(cmd_r, `BWS_ADDR_WAKE))
        out_sr_nxt = snap_wake;
      else
        out_sr_nxt = 16'h0000;
    end
  end

  always_ff @(negedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      out_sr_r <= 16'h0000;
      oe_r <= 1'b0;
    end else begin
      out_sr_r <= out_sr_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign spi_miso = out_sr_r[15];
  assign spi_miso_oe = oe_r;
endmodule : spi_status_link
`default_nettype wire

// File: hdl/bus_and_wake_status_regs.sv
// Purpose: Sticky bus fault and wake source status registers with link access
// Assumes: Event inputs come from logic on core_clk; link pins from the host
// Notes: A read returns the value frozen at frame start; a clear acts mid-frame
`timescale 1ns/10ps
`default_nettype none
`include "bus_wake_consts.svh"
// Behaviour
// - LIN fault code held at bits 6:5
// - CAN timeout flag at bit 4
// - System error at bit 3 blocks selective wake
// - CAN fault code held at bits 2:1
// - Supply undervoltage bit 0, transmitter disabled
// - Bus status zero at reset; restart keeps 6:0
// - Undervoltage monitored only in normal/receive-only
// - Timeout flag sets on silence while enabled
// - Timeout interrupt in Stop/Normal when mask set
// - System error on config error or overflow
// - Timeout clear blocked until interrupt falls
// - LIN wake bit 10, CAN wake bit 9
// - Timer two bit 8, timer one bit 7
// - Wake inputs four..one at bits 3:0
// - Wake status zero at reset; restart keeps some
// - Fail-safe entry clears wake status
module bus_and_wake_status_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic restart_req,
  input wire logic fail_safe_entry,
  input wire bus_wake_pkg::dev_mode_e dev_mode,
  input wire bus_wake_pkg::can_mode_e can_mode,
  input wire logic lin_fault_evt,
  input wire bus_wake_pkg::fault_code_e lin_fault_code,
  input wire logic can_fault_evt,
  input wire bus_wake_pkg::fault_code_e can_fault_code,
  input wire logic can_supply_low,
  input wire logic can_silent_indication,
  input wire logic selective_wake_enable_bit,
  input wire logic can_timeout_irq_mask,
  input wire logic swk_config_error,
  input wire logic [5:0] swk_error_count,
  input wire logic lin_wake_evt,
  input wire logic can_wake_evt,
  input wire logic [1:0] timer_wake_evt,
  input wire logic [3:0] input_wake_evt,
  output logic interrupt_out_n,
  output logic can_tx_disable,
  output logic selective_wake_active
);
  import bus_wake_pkg::*;

  // Link side and its crossings
  logic [7:0] link_cmd; // Stable while link valid is high
  logic link_cmd_valid;
  logic [1:0] link_sync; // {command valid, chip select}
  logic cmd_seen_r; // Last synced valid, for rise detect
  logic cmd_seen_nxt;
  logic cmd_rise;
  logic clr_bus_req;
  logic clr_wake_req;

  // Status storage
  logic [15:0] bus_fault_status_r;
  logic [15:0] bus_fault_status_nxt;
  logic [15:0] wake_source_status_r;
  logic [15:0] wake_source_status_nxt;
  logic [15:0] snap_bus_r; // Frozen copy during a frame
  logic [15:0] snap_bus_nxt;
  logic [15:0] snap_wake_r;
  logic [15:0] snap_wake_nxt;

  // Interrupt and side effects
  logic [7:0] irq_cnt_r; // Remaining low cycles of the pulse
  logic [7:0] irq_cnt_nxt;
  logic interrupt_out_n_nxt;
  logic can_timeout_flag_block_r; // Clear interlock for the timeout flag
  logic can_timeout_flag_block_nxt;
  logic can_tx_disable_nxt;
  logic selective_wake_active_nxt;

  // Combinational event terms
  logic uv_mon_en;
  logic can_timeout_flag_set;
  logic can_timeout_flag_rise;
  logic irq_ok;
  logic irq_fire;
  logic selective_wake_system_error_set;

  spi_status_link u_link (
    .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .snap_bus(snap_bus_r),
    .snap_wake(snap_wake_r),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .cmd_r(link_cmd),
    .cmd_valid_r(link_cmd_valid)
  );

  // Levels from the link domain pass two flops here
  level_sync2 #(.WIDTH(2)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in({link_cmd_valid, spi_cs_n}),
    .sync_out(link_sync)
  );

  // Command handshake: the byte is read only after its valid has crossed
  always_comb begin
    cmd_seen_nxt = ce ? link_sync[1] : cmd_seen_r;
    cmd_rise = ce & link_sync[1] & ~cmd_seen_r;
    clr_bus_req = cmd_rise & link_cmd[`BWS_CMD_CLEAR_BIT] & addr_hit(link_cmd, `BWS_ADDR_BUS);
    clr_wake_req = cmd_rise & link_cmd[`BWS_CMD_CLEAR_BIT] & addr_hit(link_cmd, `BWS_ADDR_WAKE);
  end

  // Event conditions
  always_comb begin
    uv_mon_en = (can_mode == CAN_NORMAL) || (can_mode == CAN_RX_ONLY);
    can_timeout_flag_set = selective_wake_enable_bit & can_silent_indication;
    can_timeout_flag_rise = can_timeout_flag_set & ~bus_fault_status_r[`BWS_CAN_TIMEOUT_FLAG_BIT];
    irq_ok = can_timeout_irq_mask & ((dev_mode == DEV_NORMAL) || (dev_mode == DEV_STOP));
    // A new pulse only starts from idle so that it always has a falling edge
    irq_fire = ce & can_timeout_flag_rise & irq_ok & (irq_cnt_r == 8'h00);
    selective_wake_system_error_set = selective_wake_enable_bit & (swk_config_error | (swk_error_count > `BWS_SWK_ERR_LIMIT));
  end

  // Bus fault status: clear first, then sets, so a coincident event wins
  always_comb begin
    bus_fault_status_nxt = bus_fault_status_r;
    if (ce) begin
      if (clr_bus_req)
        bus_fault_status_nxt = bus_fault_status_r & (can_timeout_flag_block_r ? `BWS_CAN_TIMEOUT_IRQ_MASK : 16'h0000);
      // First fault code is kept until cleared
      if (lin_fault_evt && bus_fault_status_nxt[`BWS_LIN_FAIL_HI:`BWS_LIN_FAIL_LO] == FLT_NONE)
        bus_fault_status_nxt[`BWS_LIN_FAIL_HI:`BWS_LIN_FAIL_LO] = lin_fault_code;
      if (can_fault_evt && bus_fault_status_nxt[`BWS_CAN_FAIL_HI:`BWS_CAN_FAIL_LO] == FLT_NONE)
        bus_fault_status_nxt[`BWS_CAN_FAIL_HI:`BWS_CAN_FAIL_LO] = can_fault_code;
      if (can_timeout_flag_set)
        bus_fault_status_nxt[`BWS_CAN_TIMEOUT_FLAG_BIT] = 1'b1;
      if (selective_wake_system_error_set)
        bus_fault_status_nxt[`BWS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT] = 1'b1;
      if (uv_mon_en && can_supply_low)
        bus_fault_status_nxt[`BWS_CAN_UV_BIT] = 1'b1;
      if (restart_req)
        bus_fault_status_nxt = bus_fault_status_nxt & `BWS_BUS_RESTART_KEEP;
      bus_fault_status_nxt = bus_fault_status_nxt & `BWS_BUS_IMPL;
    end
  end

  // Wake source status: fail-safe and host clears yield to new wake events
  always_comb begin
    wake_source_status_nxt = wake_source_status_r;
    if (ce) begin
      if (clr_wake_req || fail_safe_entry)
        wake_source_status_nxt = 16'h0000;
      if (lin_wake_evt)
        wake_source_status_nxt[`BWS_LIN_WAKE_BIT] = 1'b1;
      if (can_wake_evt)
        wake_source_status_nxt[`BWS_CAN_WAKE_BIT] = 1'b1;
      if (timer_wake_evt[1])
        wake_source_status_nxt[`BWS_TIMER2_WAKE_BIT] = 1'b1;
      if (timer_wake_evt[0])
        wake_source_status_nxt[`BWS_TIMER1_WAKE_BIT] = 1'b1;
      wake_source_status_nxt[`BWS_INPUT_WAKE_HI:`BWS_INPUT_WAKE_LO] =
        wake_source_status_nxt[`BWS_INPUT_WAKE_HI:`BWS_INPUT_WAKE_LO] | input_wake_evt;
      if (restart_req)
        wake_source_status_nxt = wake_source_status_nxt & `BWS_WAKE_RESTART_KEEP;
      wake_source_status_nxt = wake_source_status_nxt & `BWS_WAKE_IMPL;
    end
  end

  // Snapshot follows live state only between frames
  always_comb begin
    snap_bus_nxt = snap_bus_r;
    snap_wake_nxt = snap_wake_r;
    if (ce && link_sync[0]) begin
      snap_bus_nxt = bus_fault_status_r;
      snap_wake_nxt = wake_source_status_r;
    end
  end

  // Interrupt pulse, clear interlock and derived controls
  always_comb begin
    irq_cnt_nxt = irq_cnt_r;
    can_timeout_flag_block_nxt = can_timeout_flag_block_r;
    can_tx_disable_nxt = can_tx_disable;
    selective_wake_active_nxt = selective_wake_active;
    if (ce) begin
      if (irq_fire)
        irq_cnt_nxt = 8'(`BWS_INT_PULSE_CYC);
      else if (irq_cnt_r != 8'h00)
        irq_cnt_nxt = irq_cnt_r - 8'h01;
      // Lock arms with each new pulse and drops one cycle after the pin falls
      if (irq_fire)
        can_timeout_flag_block_nxt = 1'b1;
      else if (!interrupt_out_n && irq_cnt_r == 8'(`BWS_INT_PULSE_CYC))
        can_timeout_flag_block_nxt = 1'b0;
      can_tx_disable_nxt = uv_mon_en & can_supply_low;
      selective_wake_active_nxt = selective_wake_enable_bit & ~bus_fault_status_r[`BWS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT]
        & ~bus_fault_status_nxt[`BWS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT];
    end
    interrupt_out_n_nxt = (irq_cnt_nxt == 8'h00);
  end

  // Register everything; synchronous power-on or soft reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_fault_status_r <= `BWS_BUS_RESET;
      wake_source_status_r <= `BWS_WAKE_RESET;
      snap_bus_r <= 16'h0000;
      snap_wake_r <= 16'h0000;
      cmd_seen_r <= 1'b1; // Synchroniser resets high, so no false rise after reset
      irq_cnt_r <= 8'h00;
      interrupt_out_n <= 1'b1;
      can_timeout_flag_block_r <= 1'b0;
      can_tx_disable <= 1'b0;
      selective_wake_active <= 1'b0;
    end else begin
      bus_fault_status_r <= bus_fault_status_nxt;
      wake_source_status_r <= wake_source_status_nxt;
      snap_bus_r <= snap_bus_nxt;
      snap_wake_r <= snap_wake_nxt;
      cmd_seen_r <= cmd_seen_nxt;
      irq_cnt_r <= irq_cnt_nxt;
      interrupt_out_n <= interrupt_out_n_nxt;
      can_timeout_flag_block_r <= can_timeout_flag_block_nxt;
      can_tx_disable <= can_tx_disable_nxt;
      selective_wake_active <= selective_wake_active_nxt;
    end
  end

  // Checks on the core clock
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_lin_evt;
    ce && lin_fault_evt && bus_fault_status_r[6:5] == 2'b00 && !clr_bus_req;
  endsequence
  property p_lin_code;
    s_lin_evt |=> bus_fault_status_r[6:5] == $past(lin_fault_code);
  endproperty
  a_lin_code: assert property (p_lin_code) else $error("LIN code not captured");

  property p_can_code;
    ce && can_fault_evt && bus_fault_status_r[2:1] == 2'b00 |=> bus_fault_status_r[2:1] == $past(can_fault_code);
  endproperty
  a_can_code: assert property (p_can_code) else $error("CAN code not captured");

  property p_can_timeout_flag_gate;
    ce && !selective_wake_enable_bit && !bus_fault_status_r[4] |=> !bus_fault_status_r[4];
  endproperty
  a_can_timeout_flag_gate: assert property (p_can_timeout_flag_gate) else $error("Timeout set while disabled");

  property p_can_timeout_flag_set;
    ce && selective_wake_enable_bit && can_silent_indication |=> bus_fault_status_r[4];
  endproperty
  a_can_timeout_flag_set: assert property (p_can_timeout_flag_set) else $error("Timeout flag missed");

  sequence s_irq_cause;
    irq_fire;
  endsequence
  property p_irq_pulse;
    s_irq_cause |=> !interrupt_out_n [*8];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("Interrupt pulse short");

  property p_can_timeout_flag_hold;
    ce && clr_bus_req && can_timeout_flag_block_r && bus_fault_status_r[4] |=> bus_fault_status_r[4];
  endproperty
  a_can_timeout_flag_hold: assert property (p_can_timeout_flag_hold) else $error("Blocked timeout cleared");

  property p_swk_block;
    bus_fault_status_r[3] |=> !selective_wake_active;
  endproperty
  a_swk_block: assert property (p_swk_block) else $error("Selective wake active with error");

  property p_selective_wake_system_error;
    ce && selective_wake_enable_bit && swk_error_count > 6'h20 |=> bus_fault_status_r[3];
  endproperty
  a_selective_wake_system_error: assert property (p_selective_wake_system_error) else $error("System error missed");

  property p_uv;
    ce && uv_mon_en && can_supply_low |=> can_tx_disable && bus_fault_status_r[0];
  endproperty
  a_uv: assert property (p_uv) else $error("Undervoltage not handled");

  property p_uv_gate;
    ce && !uv_mon_en && !bus_fault_status_r[0] |=> !bus_fault_status_r[0];
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("Undervoltage set outside monitor");

  property p_restart;
    ce && restart_req |=> bus_fault_status_r[15:7] == 9'h000 && wake_source_status_r[6:2] == 5'h00
      && !wake_source_status_r[0];
  endproperty
  a_restart: assert property (p_restart) else $error("Restart left bits set");

  property p_fail_safe;
    ce && fail_safe_entry && !lin_wake_evt && !can_wake_evt && timer_wake_evt == 2'b00
      && input_wake_evt == 4'h0 |=> wake_source_status_r == 16'h0000;
  endproperty
  a_fail_safe: assert property (p_fail_safe) else $error("Fail-safe did not clear wake");

  property p_wake_set;
    ce && lin_wake_evt |=> wake_source_status_r[10];
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("LIN wake missed");

  property p_reserved;
    (bus_fault_status_r & ~16'h007F) == 16'h0000 && (wake_source_status_r & ~16'h078F) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set");
endmodule : bus_and_wake_status_regs
`default_nettype wire

// File: bench/spi_host_model.sv
// Purpose: Host side of the status link: sends a command byte, collects the status word
// Assumes: Mode 0, MSB first, link clock idle low and still outside frames
// Notes: Half period 24 ns; a released data line is read as the inverse of the last bit
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // Idle: deselected, clock low
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One frame: eight command bits out, sixteen status bits in
  task automatic frame(input logic [7:0] cmd, output logic [15:0] data);
    logic [23:0] sh;
    logic bit_in;
    sh = {cmd, 16'h0000};
    data = 16'h0000;
    spi_cs_n = 1'b0;
    // Odd gap keeps the link edges out of step with the core clock
    #67;
    for (int i = 0; i < 24; i++) begin
      spi_mosi = sh[23 - i];
      #24;
      spi_clk = 1'b1;
      // Undriven line never shows a value that could match by luck
      bit_in = spi_miso_oe ? spi_miso : ~data[0];
      if (i >= 8) begin
        data = {data[14:0], bit_in};
      end
      #24;
      spi_clk = 1'b0;
    end
    #24;
    spi_cs_n = 1'b1;
    // Parked data line flips so nothing relies on its old value
    spi_mosi = ~spi_mosi;
    // Deselect time lets the read snapshot refresh before the next frame
    #120;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench of the bus fault and wake source status bank
// Assumes: Host model drives the link; bench drives the event inputs 1 ns after core edges
// Notes: Clock enable is held high, so frozen-core behaviour is not exercised here
`timescale 1ns/10ps
`default_nettype none
`include "bus_wake_consts.svh"
module tb_top;
  import bus_wake_pkg::*;
  localparam int LIMIT = 30000; // Cycle ceiling, several times the expected run
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic restart_req = 1'b0;
  logic fail_safe_entry = 1'b0;
  dev_mode_e dev_mode = DEV_INIT;
  can_mode_e can_mode = CAN_OFF;
  logic lin_fault_evt = 1'b0;
  fault_code_e lin_fault_code = FLT_NONE;
  logic can_fault_evt = 1'b0;
  fault_code_e can_fault_code = FLT_NONE;
  logic can_supply_low = 1'b0;
  logic can_silent_indication = 1'b0;
  logic selective_wake_enable_bit = 1'b0;
  logic can_timeout_irq_mask = 1'b0;
  logic swk_config_error = 1'b0;
  logic [5:0] swk_error_count = 6'h00;
  logic [7:0] wake_ev = 8'h00; // LIN, CAN, timer two, timer one, inputs four..one
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic interrupt_out_n, can_tx_disable, selective_wake_active;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [3:0] mk = 4'b1011; // Mask per interrupt case
  dev_mode_e md [4] = '{DEV_NORMAL, DEV_STOP, DEV_NORMAL, DEV_SLEEP};
  int nl [4] = '{`BWS_INT_PULSE_CYC, `BWS_INT_PULSE_CYC, 0, 0}; // Expected low cycles
  int lows;
  always #5 core_clk = ~core_clk;
  spi_host_model i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  bus_and_wake_status_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .restart_req(restart_req), .fail_safe_entry(fail_safe_entry), .dev_mode(dev_mode),
    .can_mode(can_mode), .lin_fault_evt(lin_fault_evt), .lin_fault_code(lin_fault_code),
    .can_fault_evt(can_fault_evt), .can_fault_code(can_fault_code), .can_supply_low(can_supply_low),
    .can_silent_indication(can_silent_indication), .selective_wake_enable_bit(selective_wake_enable_bit),
    .can_timeout_irq_mask(can_timeout_irq_mask), .swk_config_error(swk_config_error),
    .swk_error_count(swk_error_count), .lin_wake_evt(wake_ev[7]), .can_wake_evt(wake_ev[6]),
    .timer_wake_evt(wake_ev[5:4]), .input_wake_evt(wake_ev[3:0]), .interrupt_out_n(interrupt_out_n),
    .can_tx_disable(can_tx_disable), .selective_wake_active(selective_wake_active));
  // Prints counts and verdict, then stops the run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > LIMIT) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Lands 1 ns after a core edge so inputs never race the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One link frame, then back in step with the core clock
  task automatic rdchk(input string what, input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    i_host.frame(cmd, d);
    tick(1);
    chk(what, exp, d);
  endtask : rdchk
  initial begin
    tick(5);
    rst_n = 1'b1;
    tick(2);
    // Reset values, unmapped address and idle outputs
    rdchk("bus reset", {1'b0, `BWS_ADDR_BUS}, 16'h0000);
    rdchk("wake reset", {1'b0, `BWS_ADDR_WAKE}, 16'h0000);
    rdchk("unmapped", 8'h45, 16'h0000);
    chk("pins reset", 16'h0001, {13'h0, selective_wake_active, can_tx_disable, interrupt_out_n});
    $display("test reset done");
    // Every fault code in both fields; a later fault must not overwrite the first
    for (int c = 1; c < 4; c++) begin
      lin_fault_code = fault_code_e'(c);
      can_fault_code = fault_code_e'(4 - c);
      lin_fault_evt = 1'b1;
      can_fault_evt = 1'b1;
      tick(1);
      lin_fault_code = fault_code_e'(c ^ 3);
      can_fault_code = fault_code_e'((4 - c) ^ 3);
      tick(1);
      lin_fault_evt = 1'b0;
      can_fault_evt = 1'b0;
      tick(3);
      rdchk("fault codes", {1'b1, `BWS_ADDR_BUS}, {9'h000, 2'(c), 2'b00, 2'(4 - c), 1'b0});
      rdchk("fault cleared", {1'b0, `BWS_ADDR_BUS}, 16'h0000);
    end
    $display("test fault codes done");
    // Undervoltage only counts in normal and receive-only modes; flag outlives the condition
    for (int m = 0; m < 4; m++) begin
      can_mode = can_mode_e'(m);
      can_supply_low = 1'b1;
      tick(4);
      chk("tx disable", {15'h0, 1'(m == 1 || m == 2)}, {15'h0, can_tx_disable});
      can_supply_low = 1'b0;
      tick(2);
      rdchk("undervoltage", {1'b1, `BWS_ADDR_BUS}, {15'h0, 1'(m == 1 || m == 2)});
    end
    can_mode = CAN_OFF;
    $display("test undervoltage done");
    // System error: ignored while disabled, count of 32 is no overflow, 33 is
    swk_config_error = 1'b1;
    tick(4);
    swk_config_error = 1'b0;
    rdchk("error while disabled", {1'b0, `BWS_ADDR_BUS}, 16'h0000);
    selective_wake_enable_bit = 1'b1;
    swk_error_count = `BWS_SWK_ERR_LIMIT;
    tick(4);
    chk("wake active", 16'h0001, {15'h0, selective_wake_active});
    rdchk("count at limit", {1'b0, `BWS_ADDR_BUS}, 16'h0000);
    swk_error_count = `BWS_SWK_ERR_LIMIT + 6'h01;
    tick(4);
    chk("wake blocked", 16'h0000, {15'h0, selective_wake_active});
    swk_error_count = 6'h00;
    rdchk("overflow error", {1'b1, `BWS_ADDR_BUS}, 16'h0008);
    tick(3);
    chk("wake active again", 16'h0001, {15'h0, selective_wake_active});
    swk_config_error = 1'b1;
    tick(1);
    swk_config_error = 1'b0;
    rdchk("config error", {1'b1, `BWS_ADDR_BUS}, 16'h0008);
    $display("test system error done");
    // Timeout flag and interrupt across mask and mode cases
    for (int k = 0; k < 4; k++) begin
      can_timeout_irq_mask = mk[k];
      dev_mode = md[k];
      can_silent_indication = 1'b1;
      tick(1);
      can_silent_indication = 1'b0;
      lows = 0;
      for (int n = 0; n < 150; n++) begin
        lows += (interrupt_out_n === 1'b0);
        tick(1);
      end
      chk("interrupt low cycles", 16'(nl[k]), 16'(lows));
      rdchk("timeout flag", {1'b1, `BWS_ADDR_BUS}, `BWS_CAN_TIMEOUT_IRQ_MASK);
    end
    selective_wake_enable_bit = 1'b0;
    can_silent_indication = 1'b1;
    tick(4);
    can_silent_indication = 1'b0;
    rdchk("timeout disabled", {1'b0, `BWS_ADDR_BUS}, 16'h0000);
    dev_mode = DEV_INIT;
    $display("test timeout done");
    // Each wake source lands on its own bit
    for (int k = 0; k < 8; k++) begin
      wake_ev = 8'h01 << k;
      tick(1);
      wake_ev = 8'h00;
      tick(3);
      rdchk("wake bit", {1'b1, `BWS_ADDR_WAKE}, 16'(1 << (k < 4 ? k : k + 3)));
    end
    // Restart keeps only its listed bits; fail-safe entry wipes the wake register
    wake_ev = 8'hFF;
    lin_fault_code = FLT_TSD;
    lin_fault_evt = 1'b1;
    tick(1);
    wake_ev = 8'h00;
    lin_fault_evt = 1'b0;
    tick(2);
    rdchk("all wake", {1'b0, `BWS_ADDR_WAKE}, `BWS_WAKE_IMPL);
    restart_req = 1'b1;
    tick(1);
    restart_req = 1'b0;
    tick(3);
    rdchk("wake restart", {1'b0, `BWS_ADDR_WAKE}, 16'h0782);
    rdchk("bus restart", {1'b0, `BWS_ADDR_BUS}, 16'h0020);
    fail_safe_entry = 1'b1;
    tick(1);
    fail_safe_entry = 1'b0;
    tick(3);
    rdchk("fail safe", {1'b0, `BWS_ADDR_WAKE}, 16'h0000);
    $display("test wake done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
